// >>> rtl/plcc_link_regs.sv
// Per-port link capability and link control configuration registers.
`timescale 1ns/1ns
`default_nettype none
`include "plcc_params.svh"

module plcc_link_regs
	import plcc_pkg::*;
#(
	parameter logic [7:0] PORT_INDEX = 8'h00,
	parameter bit UPSTREAM = 1'b1,
	parameter bit WIDE_MODE = 1'b0
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [11:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rdata_valid,
	input wire logic load_valid,
	input wire logic [31:0] load_data,
	input wire logic clock_request_n_release,
	output logic aspm_l0s_enable,
	output logic aspm_l1_enable,
	output logic rx_l0s_allowed,
	output logic link_disable,
	output logic retrain_pulse,
	output logic common_clock,
	output logic ext_synch,
	output logic [12:0] l0s_exit_fts_count,
	output logic [12:0] l1_exit_ts1_count,
	output logic clock_request_n,
	output logic auto_width_disable,
	output logic bw_mgmt_int_enable,
	output logic auto_bw_int_enable
);

	// True when the dword address matches a register offset.
	function automatic logic hit(input logic [11:0] addr,
		input logic [11:0] offset);
		hit = (addr[11:2] == offset[11:2]);
	endfunction : hit

	// Byte-lane merge; used for every writable control field.
	function automatic logic [31:0] merge(input logic [31:0] old_value,
		input logic [31:0] new_value, input logic [3:0] be);
		logic [31:0] lane_mask;
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		merge = (old_value & ~lane_mask) | (new_value & lane_mask);
	endfunction : merge

	// Bits that software may change; everything else ignores writes.
	function automatic logic [15:0] ctrl_writable(input bit upstream);
		logic [15:0] m;
		m = 16'h0000;
		m[`PLCC_CTL_ASPM] = 2'h3;
		m[`PLCC_CTL_COMMON_CLK] = 1'b1;
		m[`PLCC_CTL_EXT_SYNCH] = 1'b1;
		m[`PLCC_CTL_AUTO_WIDTH_DIS] = 1'b1;
		if (upstream) begin
			m[`PLCC_CTL_CLKPM_EN] = 1'b1;
		end else begin
			m[`PLCC_CTL_DISABLE] = 1'b1;
			m[`PLCC_CTL_BW_MGMT_IE] = 1'b1;
			m[`PLCC_CTL_AUTO_BW_IE] = 1'b1;
		end
		ctrl_writable = m;
	endfunction : ctrl_writable

	localparam logic [15:0] CTRL_WMASK = ctrl_writable(UPSTREAM);

	logic [1:0] aspm_sup_reg;
	logic [2:0] l0s_lat_reg;
	logic [2:0] l1_lat_reg;
	logic clkpm_cap_reg;
	logic surprise_cap_reg;
	logic bw_notify_cap_reg;
	logic [7:0] port_num_reg;
	logic [31:0] cap_view;
	logic [15:0] ctrl_reg;
	logic [31:0] ctrl_merged;
	logic cap_hit;
	logic ctrl_hit;
	plcc_aspm_type aspm_mode;

	assign cap_hit = hit(cfg_addr, `PLCC_CAP_OFFSET);
	assign ctrl_hit = hit(cfg_addr, `PLCC_CTRL_OFFSET);

	// Loadable defaults; only the load port changes them, never software.
	always_ff @(posedge clk) begin
		if (reset) begin
			aspm_sup_reg <= `PLCC_ASPM_SUP_RST;
		end else if (load_valid) begin
			aspm_sup_reg <= load_data[`PLCC_CAP_ASPM];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			l0s_lat_reg <= `PLCC_L0S_LAT_RST;
		end else if (load_valid) begin
			l0s_lat_reg <= load_data[`PLCC_CAP_L0S_LAT];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			l1_lat_reg <= `PLCC_L1_LAT_RST;
		end else if (load_valid) begin
			l1_lat_reg <= load_data[`PLCC_CAP_L1_LAT];
		end
	end

	// Downstream ports tie this off, so no load can claim clock PM there.
	always_ff @(posedge clk) begin
		if (reset) begin
			clkpm_cap_reg <= UPSTREAM;
		end else if (load_valid) begin
			clkpm_cap_reg <= UPSTREAM && load_data[`PLCC_CAP_CLKPM];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			surprise_cap_reg <= 1'b0;
		end else if (load_valid) begin
			surprise_cap_reg <= load_data[`PLCC_CAP_SURPRISE];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			bw_notify_cap_reg <= 1'b0;
		end else if (load_valid) begin
			bw_notify_cap_reg <= load_data[`PLCC_CAP_BW_NOTIFY];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			port_num_reg <= PORT_INDEX;
		end else if (load_valid) begin
			port_num_reg <= load_data[`PLCC_CAP_PORT];
		end
	end

	// Fixed fields are composed here so no load can disturb them.
	always_comb begin
		cap_view = 32'h00000000;
		cap_view[`PLCC_CAP_SPEED] = `PLCC_SPEED_5G;
		if (UPSTREAM && WIDE_MODE) begin
			cap_view[`PLCC_CAP_WIDTH] = `PLCC_WIDTH_X4;
		end else begin
			cap_view[`PLCC_CAP_WIDTH] = `PLCC_WIDTH_X1;
		end
		cap_view[`PLCC_CAP_ASPM] = aspm_sup_reg;
		cap_view[`PLCC_CAP_L0S_LAT] = l0s_lat_reg;
		cap_view[`PLCC_CAP_L1_LAT] = l1_lat_reg;
		cap_view[`PLCC_CAP_CLKPM] = clkpm_cap_reg;
		cap_view[`PLCC_CAP_SURPRISE] = surprise_cap_reg;
		cap_view[`PLCC_CAP_DLL_RPT] = !UPSTREAM;
		cap_view[`PLCC_CAP_BW_NOTIFY] = bw_notify_cap_reg;
		cap_view[`PLCC_CAP_PORT] = port_num_reg;
	end

	assign ctrl_merged = merge({16'h0000, ctrl_reg}, cfg_wdata, cfg_be);

	// Only writable bits take new data; the retrain bit is never stored.
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_reg <= 16'h0000;
		end else if (cfg_wr && ctrl_hit) begin
			ctrl_reg <= (ctrl_reg & ~CTRL_WMASK)
				| (ctrl_merged[15:0] & CTRL_WMASK);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			retrain_pulse <= 1'b0;
		end else begin
			retrain_pulse <= !UPSTREAM && cfg_wr && ctrl_hit && cfg_be[0]
				&& cfg_wdata[`PLCC_CTL_RETRAIN];
		end
	end

	// Control readback: RCB and retrain read zero, upper half belongs to
	// the link status register which this block does not hold.
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_rdata <= 32'h00000000;
		end else if (!cfg_rd) begin
			cfg_rdata <= 32'h00000000;
		end else if (cap_hit) begin
			cfg_rdata <= cap_view;
		end else if (ctrl_hit) begin
			cfg_rdata <= {16'h0000, ctrl_reg};
		end else begin
			cfg_rdata <= 32'h00000000;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_rdata_valid <= 1'b0;
		end else begin
			cfg_rdata_valid <= cfg_rd;
		end
	end

	assign aspm_mode = plcc_aspm_type'(ctrl_reg[`PLCC_CTL_ASPM]);

	always_ff @(posedge clk) begin
		if (reset) begin
			aspm_l0s_enable <= 1'b0;
			aspm_l1_enable <= 1'b0;
		end else begin
			case (aspm_mode)
				PLCC_ASPM_L0S: begin
					aspm_l0s_enable <= 1'b1;
					aspm_l1_enable <= 1'b0;
				end
				PLCC_ASPM_L1: begin
					aspm_l0s_enable <= 1'b0;
					aspm_l1_enable <= 1'b1;
				end
				PLCC_ASPM_BOTH: begin
					aspm_l0s_enable <= 1'b1;
					aspm_l1_enable <= 1'b1;
				end
				default: begin
					aspm_l0s_enable <= 1'b0;
					aspm_l1_enable <= 1'b0;
				end
			endcase
		end
	end

	// The receive side's L0s entry does not depend on the ASPM control.
	assign rx_l0s_allowed = 1'b1;

	always_ff @(posedge clk) begin
		if (reset) begin
			link_disable <= 1'b0;
		end else begin
			link_disable <= ctrl_reg[`PLCC_CTL_DISABLE];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			common_clock <= 1'b0;
		end else begin
			common_clock <= ctrl_reg[`PLCC_CTL_COMMON_CLK];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ext_synch <= 1'b0;
		end else begin
			ext_synch <= ctrl_reg[`PLCC_CTL_EXT_SYNCH];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			auto_width_disable <= 1'b0;
		end else begin
			auto_width_disable <= ctrl_reg[`PLCC_CTL_AUTO_WIDTH_DIS];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			bw_mgmt_int_enable <= 1'b0;
		end else begin
			bw_mgmt_int_enable <= ctrl_reg[`PLCC_CTL_BW_MGMT_IE];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			auto_bw_int_enable <= 1'b0;
		end else begin
			auto_bw_int_enable <= ctrl_reg[`PLCC_CTL_AUTO_BW_IE];
		end
	end

	// Ordered-set counts for leaving low power states.
	always_ff @(posedge clk) begin
		if (reset) begin
			l0s_exit_fts_count <= `PLCC_NORM_FTS_COUNT;
		end else if (ctrl_reg[`PLCC_CTL_EXT_SYNCH]) begin
			l0s_exit_fts_count <= `PLCC_EXT_FTS_COUNT;
		end else begin
			l0s_exit_fts_count <= `PLCC_NORM_FTS_COUNT;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			l1_exit_ts1_count <= `PLCC_NORM_TS1_COUNT;
		end else if (ctrl_reg[`PLCC_CTL_EXT_SYNCH]) begin
			l1_exit_ts1_count <= `PLCC_EXT_TS1_COUNT;
		end else begin
			l1_exit_ts1_count <= `PLCC_NORM_TS1_COUNT;
		end
	end

	// Released only while enabled, so disabling pulls the pin low one clock after the enable bit clears.
	always_ff @(posedge clk) begin
		if (reset) begin
			clock_request_n <= 1'b0;
		end else begin
			clock_request_n <= ctrl_reg[`PLCC_CTL_CLKPM_EN]
				&& clock_request_n_release;
		end
	end

endmodule : plcc_link_regs
`default_nettype wire

// >>> rtl/plcc_params.svh
// Offsets, field positions, reset values and counts of the link capability and control block.
`ifndef PLCC_PARAMS_SVH
`define PLCC_PARAMS_SVH

`define PLCC_CAP_OFFSET 12'h0CC
`define PLCC_CTRL_OFFSET 12'h0D0

`define PLCC_SPEED_2G5 4'h1
`define PLCC_SPEED_5G 4'h2
`define PLCC_WIDTH_X4 6'h04
`define PLCC_WIDTH_X1 6'h01
`define PLCC_ASPM_SUP_RST 2'h0
`define PLCC_L0S_LAT_RST 3'h3
`define PLCC_L1_LAT_RST 3'h0

`define PLCC_CAP_SPEED 3:0
`define PLCC_CAP_WIDTH 9:4
`define PLCC_CAP_ASPM 11:10
`define PLCC_CAP_L0S_LAT 14:12
`define PLCC_CAP_L1_LAT 17:15
`define PLCC_CAP_CLKPM 18
`define PLCC_CAP_SURPRISE 19
`define PLCC_CAP_DLL_RPT 20
`define PLCC_CAP_BW_NOTIFY 21
`define PLCC_CAP_PORT 31:24
`define PLCC_CAP_LOAD_MASK 32'hFF2FFC00

`define PLCC_CTL_ASPM 1:0
`define PLCC_CTL_RCB 3
`define PLCC_CTL_DISABLE 4
`define PLCC_CTL_RETRAIN 5
`define PLCC_CTL_COMMON_CLK 6
`define PLCC_CTL_EXT_SYNCH 7
`define PLCC_CTL_CLKPM_EN 8
`define PLCC_CTL_AUTO_WIDTH_DIS 9
`define PLCC_CTL_BW_MGMT_IE 10
`define PLCC_CTL_AUTO_BW_IE 11
`define PLCC_CTL_WIDTH 16

`define PLCC_EXT_FTS_COUNT 13'h1000
`define PLCC_EXT_TS1_COUNT 13'h0400
`define PLCC_NORM_FTS_COUNT 13'h0080
`define PLCC_NORM_TS1_COUNT 13'h0010

`endif

// >>> rtl/plcc_pkg.sv
// Types shared by the link capability and control block.
package plcc_pkg;

	typedef enum logic [1:0] {
		PLCC_ASPM_OFF,
		PLCC_ASPM_L0S,
		PLCC_ASPM_L1,
		PLCC_ASPM_BOTH
	} plcc_aspm_type;

	typedef logic [31:0] plcc_word_type;

endpackage : plcc_pkg

// >>> test/plcc_link_regs_properties.sv
// Concurrent checks on the link capability and control ports.
`timescale 1ns/1ns
`default_nettype none
module plcc_link_regs_properties #(
	parameter bit UPSTREAM = 1'b1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [11:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic aspm_l0s_enable,
	input wire logic aspm_l1_enable,
	input wire logic rx_l0s_allowed,
	input wire logic link_disable,
	input wire logic retrain_pulse,
	input wire logic ext_synch,
	input wire logic [12:0] l0s_exit_fts_count,
	input wire logic [12:0] l1_exit_ts1_count,
	input wire logic clock_request_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic ctl_wr;
	// Only writes that carry the low byte can move the ASPM, disable, retrain, common clock and sync outputs.
	assign ctl_wr = cfg_wr && cfg_addr[11:2] == 10'h034 && cfg_be[0];
	a_rx_l0s_always: assert property (rx_l0s_allowed)
		else $error("receiver L0s entry blocked");
	a_aspm_l0s_follow: assert property (ctl_wr |->
		##2 aspm_l0s_enable == $past(cfg_wdata[0], 2))
		else $error("L0s enable does not follow write");
	a_aspm_l1_follow: assert property (ctl_wr |->
		##2 aspm_l1_enable == $past(cfg_wdata[1], 2))
		else $error("L1 enable does not follow write");
	a_link_disable_follow: assert property (ctl_wr |->
		##2 link_disable == (!UPSTREAM && $past(cfg_wdata[4], 2)))
		else $error("link disable wrong after write");
	a_retrain_start: assert property (ctl_wr && cfg_wdata[5] |=>
		retrain_pulse == !UPSTREAM)
		else $error("retrain pulse wrong after write");
	a_sync_counts: assert property (ext_synch ?
		(l0s_exit_fts_count == 13'h1000 && l1_exit_ts1_count == 13'h0400) :
		(l0s_exit_fts_count == 13'h0080 && l1_exit_ts1_count == 13'h0010))
		else $error("ordered set counts wrong");
	a_clock_request_n_held_low: assert property (!UPSTREAM |-> !clock_request_n)
		else $error("clock request released on downstream port");
	a_ctl_read_zero: assert property (cfg_rd &&
		cfg_addr[11:2] == 10'h034 |=> (cfg_rdata & 32'hFFFF_F02C) == 32'h0)
		else $error("control read shows fixed-zero bits");
	a_cap_speed_fixed: assert property (cfg_rd &&
		cfg_addr[11:2] == 10'h033
		|=> cfg_rdata[3:0] == 4'h2 && cfg_rdata[23:22] == 2'h0)
		else $error("capability speed or reserved bits wrong");
	c_retrain: cover property (retrain_pulse);
	c_ext_synch: cover property (ext_synch);
	c_both_aspm: cover property (aspm_l0s_enable && aspm_l1_enable);
endmodule : plcc_link_regs_properties
`default_nettype wire

// >>> test/plcc_link_partner.sv
// Link partner model that answers clock request and counts retrains.
`timescale 1ns/1ns
`default_nettype none
module plcc_link_partner (
	input wire logic clk,
	input wire logic reset,
	input wire logic idle_req,
	input wire logic link_disable,
	input wire logic retrain_pulse,
	output logic clock_request_n_release,
	output logic [3:0] retrain_seen
);
	// A disabled link has no partner to hand its clock back to.
	always_ff @(posedge clk) begin
		clock_request_n_release <= !reset && idle_req && !link_disable;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			retrain_seen <= 4'h0;
		end else if (retrain_pulse) begin
			retrain_seen <= retrain_seen + 4'h1;
		end
	end
endmodule : plcc_link_partner
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the link capability and control registers.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import plcc_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [11:0] cfg_addr = 12'h000;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	logic [3:0] cfg_be = 4'h0;
	plcc_word_type cfg_wdata = 32'h0;
	plcc_word_type cfg_rdata;
	plcc_word_type load_data = 32'h0;
	logic load_valid = 1'b0;
	logic idle_req = 1'b0;
	logic cfg_rdata_valid, clock_request_n_release, aspm_l0s_enable, aspm_l1_enable;
	logic rx_l0s_allowed, link_disable, retrain_pulse, common_clock;
	logic ext_synch, clock_request_n, auto_width_disable;
	logic bw_mgmt_int_enable, auto_bw_int_enable;
	logic [12:0] l0s_exit_fts_count, l1_exit_ts1_count;
	logic [3:0] retrain_seen;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	// A downstream port exposes the writable disable, retrain and enables.
	plcc_link_regs #(.PORT_INDEX(8'h03), .UPSTREAM(1'b0), .WIDE_MODE(1'b0))
		DUT (.clk(clk), .reset(reset), .cfg_addr(cfg_addr),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_rdata_valid(cfg_rdata_valid), .load_valid(load_valid),
		.load_data(load_data), .clock_request_n_release(clock_request_n_release),
		.aspm_l0s_enable(aspm_l0s_enable), .aspm_l1_enable(aspm_l1_enable),
		.rx_l0s_allowed(rx_l0s_allowed), .link_disable(link_disable),
		.retrain_pulse(retrain_pulse), .common_clock(common_clock),
		.ext_synch(ext_synch), .l0s_exit_fts_count(l0s_exit_fts_count),
		.l1_exit_ts1_count(l1_exit_ts1_count),
		.clock_request_n(clock_request_n),
		.auto_width_disable(auto_width_disable),
		.bw_mgmt_int_enable(bw_mgmt_int_enable),
		.auto_bw_int_enable(auto_bw_int_enable));
	plcc_link_partner u_partner (.clk(clk), .reset(reset),
		.idle_req(idle_req), .link_disable(link_disable),
		.retrain_pulse(retrain_pulse), .clock_request_n_release(clock_request_n_release),
		.retrain_seen(retrain_seen));
	always #5 clk = ~clk;
	task automatic stop_test();
		if (bad_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [3:0] be,
		input plcc_word_type d);
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(posedge clk);
		#1;
		cfg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input plcc_word_type exp,
		input string nm);
		cfg_addr = a;
		cfg_rd = 1'b1;
		@(posedge clk);
		#1;
		cfg_rd = 1'b0;
		chk(nm, {cfg_rdata_valid, cfg_rdata[30:0]}, {1'b1, exp[30:0]});
		chk(nm, cfg_rdata, exp);
	endtask : rd
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			stop_test();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		#1;
		reset = 1'b0;
		idle_req = 1'b1;
		chk("rx_l0s", rx_l0s_allowed, 1);
		chk("fts_norm", l0s_exit_fts_count, 32'h80);
		rd(12'h0CC, 32'h0310_3012, "cap");
		rd(12'h0D0, 32'h0, "ctl");
		wr(12'h0CC, 4'hF, 32'h0);
		rd(12'h0CC, 32'h0310_3012, "cap_wr");
		wr(12'h0D0, 4'hF, 32'hFFFF_FFFF);
		settle();
		rd(12'h0D0, 32'h0ED3, "ctl_all");
		chk("disable", link_disable, 1);
		chk("common_clk", common_clock, 1);
		chk("ext_synch", ext_synch, 1);
		chk("width_dis", auto_width_disable, 1);
		chk("fts_ext", l0s_exit_fts_count, 32'h1000);
		chk("ts1_ext", l1_exit_ts1_count, 32'h400);
		chk("clock_request_n", clock_request_n, 0);
		chk("bw_ie", {bw_mgmt_int_enable, auto_bw_int_enable}, 3);
		for (int i = 0; i < 4; i++) begin
			wr(12'h0D0, 4'h1, 32'(i));
			settle();
			chk("aspm", {aspm_l1_enable, aspm_l0s_enable}, i);
			chk("rx_l0s_on", rx_l0s_allowed, 1);
		end
		chk("common_off", common_clock, 0);
		wr(12'h0D0, 4'h1, 32'h20);
		chk("retrain", retrain_pulse, 1);
		@(posedge clk);
		#1;
		chk("retrain_seen", retrain_seen, 2);
		load_data = 32'hFFFF_FFFF;
		load_valid = 1'b1;
		@(posedge clk);
		#1;
		load_valid = 1'b0;
		rd(12'h0CC, 32'hFF3B_FC12, "cap_load");
		rd(12'h100, 32'h0, "unmapped");
		reset = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		reset = 1'b0;
		chk("bw_ie_rst", {bw_mgmt_int_enable, auto_bw_int_enable}, 0);
		rd(12'h0CC, 32'h0310_3012, "cap_rst");
		rd(12'h0D0, 32'h0, "ctl_rst");
		stop_test();
	end
endmodule : tb_top
bind plcc_link_regs plcc_link_regs_properties #(.UPSTREAM(UPSTREAM))
	u_props (.clk(clk), .reset(reset), .cfg_addr(cfg_addr),
	.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_be(cfg_be),
	.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
	.aspm_l0s_enable(aspm_l0s_enable), .aspm_l1_enable(aspm_l1_enable),
	.rx_l0s_allowed(rx_l0s_allowed), .link_disable(link_disable),
	.retrain_pulse(retrain_pulse), .ext_synch(ext_synch),
	.l0s_exit_fts_count(l0s_exit_fts_count),
	.l1_exit_ts1_count(l1_exit_ts1_count),
	.clock_request_n(clock_request_n));
`default_nettype wire
